// *** rtl/epr_pkg.sv ***
/*
  Constants shared by the page 2 register block and its bus slave.
  Assumes a 32-bit AXI4-Lite bus and 16-bit management registers.
*/
`default_nettype none
package epr_pkg;
  // ==========================================================================
  // Bus and register geometry
  localparam int          ADDR_W     = 8;
  localparam int          IDX_LSB    = 2;
  localparam int          IDX_MSB    = 6;
  localparam int          IDX_W      = 5;
  localparam int          REG_W      = 16;
  localparam int          AXI_W      = 32;
  localparam int          STRB_W     = 4;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;
  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [4:0]  STD_CTRL_IDX = 5'h00;
  localparam logic [4:0]  TRIM_IDX     = 5'h10;
  localparam logic [4:0]  LOWE_IDX     = 5'h11;
  localparam logic [4:0]  PAGE2_LO     = 5'h10;
  localparam logic [4:0]  PAGE2_HI     = 5'h1e;
  localparam logic [4:0]  PAGE_SEL_IDX = 5'h1f;
  localparam int          STD_WORDS    = 31;
  // ==========================================================================
  // Page select codes and reset values
  localparam logic [15:0] PAGE_STD     = 16'h0000;
  localparam logic [15:0] PAGE_EXT2    = 16'h0002;
  localparam logic [15:0] STD_RESET    = 16'h0000;
  localparam logic [15:0] TRIM_RESET   = 16'h02be;
  localparam logic [15:0] LOWE_RESET   = 16'h0000;
  localparam logic [15:0] LOWE_RW_MASK = 16'hfc3f;
  // ==========================================================================
  // Field positions
  localparam int STD_SOFT_RST_BIT = 15;
  localparam int STD_SPEED_LO_BIT = 6;
  localparam int STD_SPEED_HI_BIT = 13;
  localparam int TE_MODE_BIT      = 15;
  localparam int LED_UNI_BIT      = 14;
  localparam int LED_INV_LSB      = 10;
  localparam int LINK_BIT         = 8;
  localparam int EEE1000_BIT      = 7;
  localparam int EEE100_BIT       = 6;
  localparam int FORCE1000_BIT    = 5;
  localparam int FORCE_LPI_BIT    = 4;
  localparam int INH100_TX_BIT    = 3;
  localparam int INH100_RX_BIT    = 2;
  localparam int INH1000_TX_BIT   = 1;
  localparam int INH1000_RX_BIT   = 0;
  localparam int LED_GROUPS       = 4;
  localparam int LED_N            = 8;
  localparam int SYNC_N           = 24;
endpackage : epr_pkg
`default_nettype wire

// *** rtl/epr_reg_if.sv ***
/*
  Register access carrier between the bus slave and the register bank.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface epr_reg_if;
  import epr_pkg::*;
  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [REG_W-1:0] wr_data;
  logic [1:0]       wr_strb;
  logic [IDX_W-1:0] rd_idx;
  logic [REG_W-1:0] rd_data;
  modport bus  (output wr_en, wr_idx, wr_data, wr_strb, rd_idx, input rd_data);
  modport regs (input wr_en, wr_idx, wr_data, wr_strb, rd_idx, output rd_data);
endinterface : epr_reg_if
`default_nettype wire

// *** rtl/epr_axil_slave.sv ***
/*
  AXI4-Lite slave: one write and one read in flight, turned into register
  strobes. Assumes a master that keeps valid and payload until taken.
*/
`default_nettype none
module epr_axil_slave import epr_pkg::*; (
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  // Write channels
  input  wire logic [ADDR_W-1:0] awaddr_in,
  input  wire logic              awvalid_in,
  output logic                   awready_out,
  input  wire logic [AXI_W-1:0]  wdata_in,
  input  wire logic [STRB_W-1:0] wstrb_in,
  input  wire logic              wvalid_in,
  output logic                   wready_out,
  output logic [1:0]             bresp_out,
  output logic                   bvalid_out,
  input  wire logic              bready_in,
  // Read channels
  input  wire logic [ADDR_W-1:0] araddr_in,
  input  wire logic              arvalid_in,
  output logic                   arready_out,
  output logic [AXI_W-1:0]       rdata_out,
  output logic [1:0]             rresp_out,
  output logic                   rvalid_out,
  input  wire logic              rready_in,
  // Register side
  epr_reg_if.bus                 reg_port
);
  // ==========================================================================
  // Decode
  function automatic logic in_map(input logic [ADDR_W-1:0] a);
    in_map = (a[ADDR_W-1:IDX_MSB+1] == '0);
  endfunction

  logic              aw_held_reg, w_held_reg, ar_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg, ar_addr_reg;
  logic [AXI_W-1:0]  w_data_reg;
  logic [STRB_W-1:0] w_strb_reg;

  // Address and data come in either order; the write fires with both held.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      awready_out <= 1'b1;
      wready_out  <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_out  <= 1'b0;
      bresp_out   <= RESP_OKAY;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_held_reg <= 1'b1;
        awready_out <= 1'b0;
        aw_addr_reg <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        w_held_reg <= 1'b1;
        wready_out <= 1'b0;
        w_data_reg <= wdata_in;
        w_strb_reg <= wstrb_in;
      end
      if (aw_held_reg && w_held_reg && !bvalid_out) begin
        bvalid_out  <= 1'b1;
        bresp_out   <= in_map(aw_addr_reg) ? RESP_OKAY : RESP_DECERR;
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
      end
      // Ready returns only after the response, so one write is in flight.
      if (bvalid_out && bready_in) begin
        bvalid_out  <= 1'b0;
        awready_out <= 1'b1;
        wready_out  <= 1'b1;
      end
    end
  end

  // Read: address taken, data sampled next cycle, held until rready.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      arready_out <= 1'b1;
      ar_held_reg <= 1'b0;
      ar_addr_reg <= '0;
      rvalid_out  <= 1'b0;
      rdata_out   <= '0;
      rresp_out   <= RESP_OKAY;
    end else begin
      if (arvalid_in && arready_out) begin
        ar_held_reg <= 1'b1;
        arready_out <= 1'b0;
        ar_addr_reg <= araddr_in;
      end
      if (ar_held_reg && !rvalid_out) begin
        rvalid_out  <= 1'b1;
        ar_held_reg <= 1'b0;
        rdata_out   <= in_map(ar_addr_reg) ? {16'h0000, reg_port.rd_data} : '0;
        rresp_out   <= in_map(ar_addr_reg) ? RESP_OKAY : RESP_DECERR;
      end
      if (rvalid_out && rready_in) begin
        rvalid_out  <= 1'b0;
        arready_out <= 1'b1;
      end
    end
  end

  // Strobes toward the register bank; unmapped writes store nothing.
  assign reg_port.wr_en   = aw_held_reg && w_held_reg && !bvalid_out && in_map(aw_addr_reg);
  assign reg_port.wr_idx  = aw_addr_reg[IDX_MSB:IDX_LSB];
  assign reg_port.wr_data = w_data_reg[REG_W-1:0];
  assign reg_port.wr_strb = w_strb_reg[1:0];
  assign reg_port.rd_idx  = ar_addr_reg[IDX_MSB:IDX_LSB];
endmodule : epr_axil_slave
`default_nettype wire

// *** rtl/epr_page2_regs.sv ***
/*
  Management register space of one copper port with a banked page 2:
  transmit amplitude trim and low-energy, indicator and debug controls.
  Assumes software on AXI4-Lite and asynchronous status and LED inputs.
*/
// Notes on behaviour
// R1 - Writing 0x0002 to register 31 selects extended page 2.
// R2 - With page 2 selected, registers 16 to 30 reach page 2.
// R3 - Registers 0 to 15 always reach the standard space.
// R4 - Writing 0x0000 to register 31 restores standard registers 16 to 30.
// R5 - Trim bits 11:8 hold the 100BASE-TX amplitude code, reset 0010.
// R6 - Trim bits 3:0 hold the 10BASE-Te amplitude code, reset 1110.
// R7 - Control bit 15 enables low-energy 10BASE-Te mode, sticky, reset low.
// R8 - Control bit 14 keeps indicators alive in fiber unidirectional mode.
// R9 - Bits 13:10 invert indicator polarity; default is active low.
// R10 - Polarity inversion also applies to the serial indicator stream.
// R11 - Bits 8, 7, 6 report link, gigabit and fast low-energy status.
// R12 - Bit 5 allows forced gigabit link when register 0 bits 6,13 are 10.
// R13 - Bit 4 makes the generator send LPI and ignore MAC data.
// R14 - Bit 3 blocks LPI toward media in 100BASE-TX mode.
// R15 - Bit 2 blocks LPI toward the MAC in 100BASE-TX mode.
// R16 - Bit 1 blocks LPI toward media in 1000BASE-T mode.
// R17 - Bit 0 blocks LPI toward the MAC in 1000BASE-T mode.
// R18 - Software leaves bits 4:0 alone outside debugging.
// R19 - Sticky fields survive a software reset; only hardware reset clears them.
`default_nettype none
module epr_page2_regs import epr_pkg::*; (
  // Clock and hardware reset
  input  wire logic              clock_in,
  input  wire logic              reset_in,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] awaddr_in,
  input  wire logic              awvalid_in,
  output logic                   awready_out,
  input  wire logic [AXI_W-1:0]  wdata_in,
  input  wire logic [STRB_W-1:0] wstrb_in,
  input  wire logic              wvalid_in,
  output logic                   wready_out,
  output logic [1:0]             bresp_out,
  output logic                   bvalid_out,
  input  wire logic              bready_in,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] araddr_in,
  input  wire logic              arvalid_in,
  output logic                   arready_out,
  output logic [AXI_W-1:0]       rdata_out,
  output logic [1:0]             rresp_out,
  output logic                   rvalid_out,
  input  wire logic              rready_in,
  // Port status from the line side
  input  wire logic              link_up_in,
  input  wire logic              eee_1000_active_in,
  input  wire logic              eee_100_active_in,
  input  wire logic              speed_1000_in,
  input  wire logic              speed_100_in,
  input  wire logic              fiber_unidir_in,
  // Low power idle signalling
  input  wire logic              mac_tx_lpi_in,
  input  wire logic              media_rx_lpi_in,
  output logic                   media_tx_lpi_out,
  output logic                   mac_rx_lpi_out,
  output logic                   test_packet_generator_lpi_out,
  // Indicator functions and pins
  input  wire logic [LED_N-1:0]  led_function_in,
  input  wire logic [LED_N-1:0]  serial_led_function_in,
  output logic [LED_N-1:0]       indicator_outputs_out,
  output logic [LED_N-1:0]       serial_indicator_out,
  // Controls toward the copper media
  output logic [REG_W-1:0]       copper_media_transmit_trim_out,
  output logic                   te_mode_out,
  output logic                   force_1000_no_role_out,
  output logic                   soft_reset_out
);
  // ==========================================================================
  // Bus slave
  epr_reg_if reg_bus ();

  epr_axil_slave u_slave (
    .clock_in    (clock_in),
    .reset_in    (reset_in),
    .awaddr_in   (awaddr_in),
    .awvalid_in  (awvalid_in),
    .awready_out (awready_out),
    .wdata_in    (wdata_in),
    .wstrb_in    (wstrb_in),
    .wvalid_in   (wvalid_in),
    .wready_out  (wready_out),
    .bresp_out   (bresp_out),
    .bvalid_out  (bvalid_out),
    .bready_in   (bready_in),
    .araddr_in   (araddr_in),
    .arvalid_in  (arvalid_in),
    .arready_out (arready_out),
    .rdata_out   (rdata_out),
    .rresp_out   (rresp_out),
    .rvalid_out  (rvalid_out),
    .rready_in   (rready_in),
    .reg_port    (reg_bus.bus)
  );

  // ==========================================================================
  // Input synchronisers
  // Inputs from other domains pass two flops;
  // only the second stage is read.
  logic [SYNC_N-1:0] sync_raw;
  logic [SYNC_N-1:0] sync_meta_reg;
  logic [SYNC_N-1:0] sync_reg;

  assign sync_raw = {serial_led_function_in, led_function_in, media_rx_lpi_in,
                     mac_tx_lpi_in, fiber_unidir_in, speed_100_in, speed_1000_in,
                     eee_100_active_in, eee_1000_active_in, link_up_in};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge clock_in) begin
        if (reset_in) begin
          sync_meta_reg[gi] <= 1'b0;
          sync_reg[gi]      <= 1'b0;
        end else begin
          sync_meta_reg[gi] <= sync_raw[gi];
          sync_reg[gi]      <= sync_meta_reg[gi];
        end
      end
    end
  endgenerate

  logic             link_up_s, eee_1000_s, eee_100_s;
  logic             speed_1000_s, speed_100_s, fiber_unidir_s;
  logic             mac_tx_lpi_s, media_rx_lpi_s;
  logic [LED_N-1:0] led_function_s, serial_led_function_s;

  assign link_up_s             = sync_reg[0];
  assign eee_1000_s            = sync_reg[1];
  assign eee_100_s             = sync_reg[2];
  assign speed_1000_s          = sync_reg[3];
  assign speed_100_s           = sync_reg[4];
  assign fiber_unidir_s        = sync_reg[5];
  assign mac_tx_lpi_s          = sync_reg[6];
  assign media_rx_lpi_s        = sync_reg[7];
  assign led_function_s        = sync_reg[15:8];
  assign serial_led_function_s = sync_reg[23:16];

  // ==========================================================================
  // Access helpers
  // Byte-lane merge shared by every writable register.
  function automatic logic [REG_W-1:0] merge_lanes(input logic [REG_W-1:0] old_v,
                                                   input logic [REG_W-1:0] new_v,
                                                   input logic [1:0]       strb);
    merge_lanes = {strb[1] ? new_v[15:8] : old_v[15:8],
                   strb[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  // True where an index lands on page 2.
  function automatic logic on_page2(input logic [REG_W-1:0] page_sel,
                                    input logic [IDX_W-1:0] idx);
    on_page2 = (page_sel == PAGE_EXT2) && (idx >= PAGE2_LO) && (idx <= PAGE2_HI); // R1 R2 R3
  endfunction

  // ==========================================================================
  // Page select
  // Only 0x0002 opens page 2; any other value keeps the
  // standard space, so a stray value cannot expose page 2.
  logic [REG_W-1:0] page_sel_reg;
  logic [REG_W-1:0] page_sel_next;
  logic             wr_page_sel;

  assign wr_page_sel   = reg_bus.wr_en && (reg_bus.wr_idx == PAGE_SEL_IDX);
  assign page_sel_next = merge_lanes(page_sel_reg, reg_bus.wr_data, reg_bus.wr_strb);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      page_sel_reg <= PAGE_STD;
    end else if (wr_page_sel) begin
      page_sel_reg <= page_sel_next; // R1 R4
    end
  end

  // ==========================================================================
  // Standard register space
  // Standard registers 0 to 30 are plain words. Register 0
  // bit 15 is a self-clearing software reset.
  logic [REG_W-1:0] std_mem [STD_WORDS];
  logic             wr_std, wr_page2;
  logic [REG_W-1:0] std_wr_value;

  assign wr_page2     = reg_bus.wr_en && on_page2(page_sel_reg, reg_bus.wr_idx);
  assign wr_std       = reg_bus.wr_en && !wr_page2 && (reg_bus.wr_idx != PAGE_SEL_IDX); // R3
  assign std_wr_value = merge_lanes(std_mem[reg_bus.wr_idx], reg_bus.wr_data,
                                    reg_bus.wr_strb);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      for (int i = 0; i < STD_WORDS; i++) begin
        std_mem[i] <= STD_RESET;
      end
    end else if (wr_std) begin
      std_mem[reg_bus.wr_idx] <= std_wr_value; // R2 R4
      if (reg_bus.wr_idx == STD_CTRL_IDX) begin
        std_mem[STD_CTRL_IDX][STD_SOFT_RST_BIT] <= 1'b0;
      end
    end
  end

  // One-cycle software reset pulse for non-sticky state.
  logic soft_rst;

  assign soft_rst = wr_std && (reg_bus.wr_idx == STD_CTRL_IDX) &&
                    reg_bus.wr_strb[1] && reg_bus.wr_data[STD_SOFT_RST_BIT];

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      soft_reset_out <= 1'b0;
    end else begin
      soft_reset_out <= soft_rst;
    end
  end

  // ==========================================================================
  // Page 2: transmit amplitude trim
  // Not sticky: a software reset restores the codes.
  logic [REG_W-1:0] trim_reg;
  logic [REG_W-1:0] trim_next;
  logic             wr_trim;

  assign wr_trim   = wr_page2 && (reg_bus.wr_idx == TRIM_IDX);
  assign trim_next = merge_lanes(trim_reg, reg_bus.wr_data, reg_bus.wr_strb);

  always_ff @(posedge clock_in) begin
    if (reset_in || soft_rst) begin
      trim_reg <= TRIM_RESET; // R5 R6
    end else if (wr_trim) begin
      trim_reg <= trim_next; // R5 R6
    end
  end

  // ==========================================================================
  // Page 2: low-energy, indicator and debug control
  // Writable fields are sticky: only hardware reset clears them.
  // Bits 9:6 are read-only.
  logic [REG_W-1:0] lowe_reg;
  logic [REG_W-1:0] lowe_next;
  logic             wr_lowe;

  assign wr_lowe   = wr_page2 && (reg_bus.wr_idx == LOWE_IDX);
  assign lowe_next = merge_lanes(lowe_reg, reg_bus.wr_data, reg_bus.wr_strb) & LOWE_RW_MASK;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      lowe_reg <= LOWE_RESET; // R19
    end else if (wr_lowe) begin
      lowe_reg <= lowe_next; // R7 R8 R9 R12 R13 R14 R15 R16 R17 R19
    end
  end

  // ==========================================================================
  // Read multiplexer
  // Unused page 2 slots read as zero and ignore writes.
  logic [REG_W-1:0] lowe_view;

  assign lowe_view = {lowe_reg[TE_MODE_BIT:LED_INV_LSB], 1'b0,
                      link_up_s, eee_1000_s, eee_100_s, // R11
                      lowe_reg[FORCE1000_BIT:INH1000_RX_BIT]};

  always_comb begin
    if (reg_bus.rd_idx == PAGE_SEL_IDX) begin
      reg_bus.rd_data = page_sel_reg;
    end else if (on_page2(page_sel_reg, reg_bus.rd_idx)) begin
      if (reg_bus.rd_idx == TRIM_IDX) begin
        reg_bus.rd_data = trim_reg;
      end else if (reg_bus.rd_idx == LOWE_IDX) begin
        reg_bus.rd_data = lowe_view;
      end else begin
        reg_bus.rd_data = '0;
      end
    end else begin
      reg_bus.rd_data = std_mem[reg_bus.rd_idx]; // R3
    end
  end

  // ==========================================================================
  // Indicator pins
  // Both indicators of a group share its invert bit. In fiber
  // unidirectional mode they go dark unless bit 14 is set.
  logic             led_allowed;
  logic [LED_N-1:0] led_invert;

  assign led_allowed = !fiber_unidir_s || lowe_reg[LED_UNI_BIT]; // R8

  generate
    for (gi = 0; gi < LED_N; gi++) begin : g_led_inv
      assign led_invert[gi] = lowe_reg[LED_INV_LSB + (gi % LED_GROUPS)];
    end
  endgenerate

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      indicator_outputs_out <= '1;
      serial_indicator_out  <= '1;
    end else begin
      indicator_outputs_out <= ~(led_function_s & {LED_N{led_allowed}}) ^ led_invert; // R9
      serial_indicator_out  <= ~(serial_led_function_s & {LED_N{led_allowed}})
                               ^ led_invert; // R10
    end
  end

  // ==========================================================================
  // Low power idle steering
  // Forced LPI wins over the inhibits: the generator
  // then owns the media path.
  logic tx_block, rx_block;

  assign tx_block = (speed_100_s && lowe_reg[INH100_TX_BIT]) ||    // R14
                    (speed_1000_s && lowe_reg[INH1000_TX_BIT]);    // R16
  assign rx_block = (speed_100_s && lowe_reg[INH100_RX_BIT]) ||    // R15
                    (speed_1000_s && lowe_reg[INH1000_RX_BIT]);    // R17

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      media_tx_lpi_out              <= 1'b0;
      mac_rx_lpi_out                <= 1'b0;
      test_packet_generator_lpi_out <= 1'b0;
    end else begin
      test_packet_generator_lpi_out <= lowe_reg[FORCE_LPI_BIT]; // R13
      media_tx_lpi_out <= lowe_reg[FORCE_LPI_BIT] || (mac_tx_lpi_s && !tx_block); // R13
      mac_rx_lpi_out   <= media_rx_lpi_s && !rx_block;
    end
  end

  // ==========================================================================
  // Copper media controls
  // Forced gigabit without a role needs register 0 bits 6,13 at 1,0.
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      copper_media_transmit_trim_out <= TRIM_RESET;
      te_mode_out                    <= 1'b0;
      force_1000_no_role_out         <= 1'b0;
    end else begin
      copper_media_transmit_trim_out <= trim_reg; // R5 R6
      te_mode_out                    <= lowe_reg[TE_MODE_BIT]; // R7
      force_1000_no_role_out         <= lowe_reg[FORCE1000_BIT] &&
                                        std_mem[STD_CTRL_IDX][STD_SPEED_LO_BIT] &&
                                        !std_mem[STD_CTRL_IDX][STD_SPEED_HI_BIT]; // R12
    end
  end

endmodule : epr_page2_regs
`default_nettype wire

// *** bench/epr_page2_regs_chk.sv ***
/* Port checker for the page 2 register block.
   Assumes it is bound to epr_page2_regs and sees its ports only. */
`default_nettype none
module epr_page2_regs_chk import epr_pkg::*; (
  // Clock, reset and bus handshakes
  input wire logic              clock_in, reset_in, awvalid_in, awready_out, wvalid_in,
  input wire logic              wready_out, bvalid_out, bready_in, arvalid_in, arready_out,
  input wire logic              rvalid_out, rready_in,
  input wire logic [ADDR_W-1:0] araddr_in,
  input wire logic [AXI_W-1:0]  rdata_out,
  input wire logic [1:0]        rresp_out,
  // Line side outputs
  input wire logic [LED_N-1:0]  indicator_outputs_out,
  input wire logic [REG_W-1:0]  copper_media_transmit_trim_out,
  input wire logic              te_mode_out, media_tx_lpi_out, soft_reset_out,
  input wire logic              test_packet_generator_lpi_out
);
  // ==========================================================================
  // One clock; reset masks all checks.
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  sequence s_wr_taken; awvalid_in && awready_out && wvalid_in && wready_out; endsequence
  sequence s_rd_taken; arvalid_in && arready_out; endsequence
  a_write_answer: assert property (s_wr_taken |=> !awready_out ##1 bvalid_out)
    else $error("write answer out of step");
  a_read_answer: assert property (s_rd_taken |=> !arready_out ##1 rvalid_out)
    else $error("read answer out of step");
  a_bresp_taken: assert property (bvalid_out && bready_in |=> !bvalid_out && awready_out)
    else $error("write response not retired");
  a_rdata_taken: assert property (rvalid_out && rready_in |=> !rvalid_out && arready_out)
    else $error("read response not retired");
  a_unmapped_read: assert property (s_rd_taken ##0 araddr_in[7] |-> ##2 rvalid_out &&
    rresp_out == RESP_DECERR && rdata_out == 32'h0) else $error("unmapped read answered");
  a_reset_values: assert property ($fell(reset_in) |-> indicator_outputs_out == 8'hff &&
    copper_media_transmit_trim_out == TRIM_RESET && !te_mode_out) else $error("reset values");
  a_forced_lpi: assert property (test_packet_generator_lpi_out |-> media_tx_lpi_out)
    else $error("forced idle not sent");
  a_soft_trim: assert property ($rose(soft_reset_out) |-> ##[0:2]
    copper_media_transmit_trim_out == TRIM_RESET) else $error("trim kept through soft reset");
  a_soft_pulse: assert property (soft_reset_out |=> !soft_reset_out)
    else $error("soft reset pulse too long");
endmodule // epr_page2_regs_chk
bind epr_page2_regs epr_page2_regs_chk i_chk (.clock_in, .reset_in, .awvalid_in, .awready_out,
  .wvalid_in, .wready_out, .bvalid_out, .bready_in, .arvalid_in, .arready_out, .rvalid_out,
  .rready_in, .araddr_in, .rdata_out, .rresp_out, .indicator_outputs_out, .te_mode_out,
  .copper_media_transmit_trim_out, .media_tx_lpi_out, .soft_reset_out,
  .test_packet_generator_lpi_out);
`default_nettype wire

// *** bench/tb.sv ***
/* Self-checking bench for the page 2 register block.
   Assumes AXI4-Lite timing and a synchronous reset. */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Stimulus and observed signals
  logic        clock_in = '0, reset_in = '1, awvalid_in = '0, wvalid_in = '0, bready_in = '0;
  logic        arvalid_in = '0, rready_in = '0, link_up_in = '0, eee_1000_active_in = '0;
  logic        eee_100_active_in = '0, speed_1000_in = '0, speed_100_in = '0;
  logic        fiber_unidir_in = '0, mac_tx_lpi_in = '0, media_rx_lpi_in = '0;
  logic [7:0]  awaddr_in = '0, araddr_in = '0, led_function_in = '0, serial_led_function_in = '0;
  logic [31:0] wdata_in = '0, rdata_out;
  logic [3:0]  wstrb_in = 4'hf;
  logic [1:0]  bresp_out, rresp_out;
  logic [7:0]  indicator_outputs_out, serial_indicator_out;
  logic [15:0] copper_media_transmit_trim_out;
  logic        awready_out, wready_out, bvalid_out, arready_out, rvalid_out, te_mode_out;
  logic        media_tx_lpi_out, mac_rx_lpi_out, test_packet_generator_lpi_out;
  logic        force_1000_no_role_out, soft_reset_out;
  int          errors = 0, checks = 0, cycles = 0, seed = 60685;
  epr_page2_regs i_epr_page2_regs (.*);
  // The cycle ceiling cuts a hung handshake short.
  always #5 clock_in = ~clock_in;
  always @(posedge clock_in) if (++cycles == 5000) begin errors++; close_out; end
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin errors++; $display("Error %s expected %h seen %h", n, e, s); end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Both channels offered together; each drops once taken.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic ta, tw, tv;
    @(posedge clock_in);
    awaddr_in <= a; wdata_in <= {16'h0, d}; awvalid_in <= '1; wvalid_in <= '1; bready_in <= '1;
    do begin
      #1 ta = awready_out; tw = wready_out; tv = bvalid_out;
      @(posedge clock_in);
      if (ta) awvalid_in <= '0;
      if (tw) wvalid_in <= '0;
    end while (!tv);
    bready_in <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] r = 2'h0);
    logic ta, tv; logic [31:0] q; logic [1:0] p;
    @(posedge clock_in);
    araddr_in <= a; arvalid_in <= '1; rready_in <= '1;
    do begin
      #1 ta = arready_out; tv = rvalid_out; q = rdata_out; p = rresp_out;
      @(posedge clock_in);
      if (ta) arvalid_in <= '0;
    end while (!tv);
    rready_in <= '0;
    chk("rdata", q, 32'(e));
    chk("rresp", 32'(p), 32'(r));
  endtask
  // Active low unless inverted; dark in fiber unidirectional mode unless bit 14 is set.
  function automatic logic [7:0] led_exp(logic [7:0] f, logic [15:0] c, logic u);
    for (int i = 0; i < 8; i++) led_exp[i] = ~(f[i] & (~u | c[14])) ^ c[10 + i % 4];
  endfunction
  initial begin
    logic [15:0] c, t;
    repeat (3) @(posedge clock_in);
    reset_in <= '0;
    #1 chk("leds", 32'(indicator_outputs_out), 32'hff);
    wr(8'h40, 16'h1234);
    wr(8'h7c, 16'h0002);
    rd(8'h40, 16'h02be);
    rd(8'h44, 16'h0000);
    wr(8'h14, 16'h5a5a);
    rd(8'h14, 16'h5a5a);
    $display("test paging done");
    for (int i = 0; i < 10; i++) begin
      c = (i == 0) ? 16'hffff : $random(seed);
      t = $random(seed);
      {link_up_in, eee_1000_active_in, eee_100_active_in, speed_1000_in, speed_100_in,
       fiber_unidir_in, mac_tx_lpi_in, media_rx_lpi_in, led_function_in,
       serial_led_function_in} <= $random(seed);
      wr(8'h44, c);
      wr(8'h40, t);
      repeat (6) @(posedge clock_in);
      rd(8'h44, (c & 16'hfc3f) | {7'h0, link_up_in, eee_1000_active_in, eee_100_active_in, 6'h0});
      rd(8'h40, t);
      #1 chk("trim", 32'(copper_media_transmit_trim_out), 32'(t));
      chk("te", 32'(te_mode_out), 32'(c[15]));
      chk("gen", 32'(test_packet_generator_lpi_out), 32'(c[4]));
      chk("txlpi", 32'(media_tx_lpi_out), 32'(c[4] | (mac_tx_lpi_in &
        !((speed_100_in & c[3]) | (speed_1000_in & c[1])))));
      chk("rxlpi", 32'(mac_rx_lpi_out), 32'(media_rx_lpi_in &
        !((speed_100_in & c[2]) | (speed_1000_in & c[0]))));
      chk("leds", 32'(indicator_outputs_out), 32'(led_exp(led_function_in, c, fiber_unidir_in)));
      chk("sled", 32'(serial_indicator_out), 32'(led_exp(serial_led_function_in, c, fiber_unidir_in)));
    end
    $display("test controls done");
    wr(8'h00, 16'h0040);
    #1 chk("force", 32'(force_1000_no_role_out), 32'(c[5]));
    wr(8'h00, 16'h8040);
    rd(8'h40, 16'h02be);
    rd(8'h7c, 16'h0002);
    rd(8'h44, (c & 16'hfc3f) | {7'h0, link_up_in, eee_1000_active_in, eee_100_active_in, 6'h0});
    wr(8'h7c, 16'h0000);
    rd(8'h40, 16'h1234);
    rd(8'h80, 16'h0000, 2'h3);
    $display("test soft reset done");
    close_out;
  end
endmodule // tb
`default_nettype wire
